// ===== core/lin_register_interface.sv
// Register interface of the link controller: config, pointer, data port.
// Assumes a framing engine on the same clock reports events each cycle.
`timescale 1ns/1ps
`include "lin_regs_cfg.svh"
module lin_register_interface
  import lin_regs_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // Special-function bus
  input  wire logic [7:0]       sfr_addr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  output logic      [7:0]       sfr_rdata,
  // Framing engine
  input  wire engine_event_type eng_evt,
  input  wire logic [7:0]       eng_rx_byte,
  input  wire logic [2:0]       eng_rx_index,
  input  wire logic             eng_rx_valid,
  input  wire logic [5:0]       eng_rx_id,
  input  wire logic             eng_rx_id_valid,
  input  wire logic             eng_break_seen,
  output link_config_type       cfg_out,
  output logic      [7:0]       ctrl_out,
  output logic      [7:0]       length_out,
  output logic      [7:0]       divider_out,
  output logic      [7:0]       multiplier_out,
  output logic      [7:0]       identifier_out,
  output logic                  use_auto_baud,
  output logic                  engine_halted,
  output logic                  interrupt_pending
);
  logic [7:0] cfg_r, cfg_nxt, ptr_r, ptr_nxt, ctrl_r, ctrl_nxt;
  logic [7:0] stat_r, stat_nxt, err_r, err_nxt, len_r, len_nxt;
  logic [7:0] div_r, div_nxt, mul_r, mul_nxt, id_r, id_nxt;
  logic       halt_r, halt_nxt, int_r, int_nxt;
  logic [7:0] frame_r [8];
  logic [7:0] frame_nxt [8];
  logic [7:0] rdata_r, rdata_nxt;
  logic       is_master, is_slave, data_wr, buf_ok, finish;

  function automatic logic [7:0] ctrl_view(input logic [7:0] c,
                                           input logic m);
    logic [7:0] v;
    v = c;
    v[`CTRL_CLR_INT] = 1'b0;
    v[`CTRL_CLR_ERR] = 1'b0;
    v[`CTRL_STOP]    = 1'b0;
    if (m) begin
      v[`CTRL_SLEEP] = 1'b0;
      v[`CTRL_ACK]   = 1'b0;
    end else begin
      v[`CTRL_START] = 1'b0;
    end
    return v;
  endfunction : ctrl_view

  assign is_master = cfg_r[`CFG_MASTER];
  assign is_slave  = ~cfg_r[`CFG_MASTER];
  assign data_wr   = sfr_wr && (sfr_addr == `DATA_ADDR);
  // Slave may only touch buffer and id during an idle data request
  assign buf_ok = is_master ||
                  (stat_r[`ST_REQ] && !stat_r[`ST_ACTIVE]);
  assign finish = eng_evt.done || eng_evt.error;

  always_comb begin
    cfg_nxt  = cfg_r;
    ptr_nxt  = ptr_r;
    ctrl_nxt = ctrl_r;
    len_nxt  = len_r;
    div_nxt  = div_r;
    mul_nxt  = mul_r;
    id_nxt   = id_r;
    halt_nxt = halt_r;
    frame_nxt = frame_r;
    if (sfr_wr && sfr_addr == `CFG_ADDR)
      cfg_nxt = sfr_wdata & `CFG_MASK;
    if (sfr_wr && sfr_addr == `PTR_ADDR)
      ptr_nxt = sfr_wdata;
    if (data_wr) begin
      if (ptr_r[3:0] <= `IDX_FRAME_LAST && ptr_r[7:4] == 4'h0 && buf_ok)
        frame_nxt[ptr_r[2:0]] = sfr_wdata;
      unique case (ptr_r)
        {4'h0, `IDX_CTRL}: begin
          ctrl_nxt[`CTRL_DIR]  = sfr_wdata[`CTRL_DIR];
          ctrl_nxt[`CTRL_WAKE] = ctrl_r[`CTRL_WAKE] | sfr_wdata[`CTRL_WAKE];
          if (is_master)
            ctrl_nxt[`CTRL_START] = ctrl_r[`CTRL_START] |
                                    sfr_wdata[`CTRL_START];
          if (is_slave) begin
            ctrl_nxt[`CTRL_SLEEP] = sfr_wdata[`CTRL_SLEEP];
            ctrl_nxt[`CTRL_ACK]   = ctrl_r[`CTRL_ACK] |
                                    sfr_wdata[`CTRL_ACK];
            if (sfr_wdata[`CTRL_STOP])
              halt_nxt = 1'b1;
          end
        end
        {4'h0, `IDX_LEN}: len_nxt = sfr_wdata;
        {4'h0, `IDX_DIV}: div_nxt = sfr_wdata;
        {4'h0, `IDX_MUL}: mul_nxt = sfr_wdata;
        {4'h0, `IDX_ID}:  if (buf_ok) id_nxt = sfr_wdata & `ID_MASK;
        default: ;
      endcase
    end
    if (eng_rx_valid)
      frame_nxt[eng_rx_index] = eng_rx_byte;
    if (eng_rx_id_valid)
      id_nxt = {2'b00, eng_rx_id};
    if (eng_break_seen)
      halt_nxt = 1'b0;
    if (finish) begin
      ctrl_nxt[`CTRL_START] = 1'b0;
      ctrl_nxt[`CTRL_WAKE]  = 1'b0;
      ctrl_nxt[`CTRL_ACK]   = 1'b0;
    end
    ctrl_nxt[`CTRL_STOP]    = 1'b0;
    ctrl_nxt[`CTRL_CLR_INT] = 1'b0;
    ctrl_nxt[`CTRL_CLR_ERR] = 1'b0;
  end

  // Status and errors: hardware set wins over a same-cycle software clear
  always_comb begin
    logic clr_int, clr_err;
    clr_int = data_wr && ptr_r == {4'h0, `IDX_CTRL} &&
              sfr_wdata[`CTRL_CLR_INT];
    clr_err = data_wr && ptr_r == {4'h0, `IDX_CTRL} &&
              sfr_wdata[`CTRL_CLR_ERR];
    stat_nxt = stat_r;
    err_nxt  = err_r;
    int_nxt  = int_r;
    if (clr_int) int_nxt = 1'b0;
    if (clr_err) begin
      err_nxt = 8'h00;
      stat_nxt[`ST_ERR] = 1'b0;
    end
    stat_nxt[`ST_ACTIVE] = eng_evt.active;
    if (eng_evt.done)         stat_nxt[`ST_DONE] = 1'b1;
    if (eng_evt.wakeup)       stat_nxt[`ST_WAKE] = 1'b1;
    if (eng_evt.error)        stat_nxt[`ST_ERR] = 1'b1;
    if (eng_evt.data_request) stat_nxt[`ST_REQ] = 1'b1;
    if (finish || eng_evt.abort) stat_nxt[`ST_REQ] = 1'b0;
    if (eng_evt.abort)        stat_nxt[`ST_ABORT] = 1'b1;
    if (eng_break_seen && !eng_evt.abort) stat_nxt[`ST_ABORT] = 1'b0;
    if (eng_evt.idle_timeout) stat_nxt[`ST_IDLE] = 1'b1;
    err_nxt = err_nxt | (eng_evt.err_flags & `ERR_USED_MASK);
    if (finish || eng_evt.data_request || eng_evt.wakeup ||
        eng_evt.idle_timeout) begin
      int_nxt = 1'b1;
    end
    stat_nxt[`ST_INT] = int_nxt;
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      rdata_nxt = 8'h00;
      if (sfr_addr == `CFG_ADDR) rdata_nxt = cfg_r;
      else if (sfr_addr == `PTR_ADDR) rdata_nxt = ptr_r;
      else if (sfr_addr == `DATA_ADDR && ptr_r[7:4] == 4'h0) begin
        if (ptr_r[3:0] <= `IDX_FRAME_LAST)
          rdata_nxt = buf_ok ? frame_r[ptr_r[2:0]] : 8'h00;
        else
          unique case (ptr_r[3:0])
            `IDX_CTRL:   rdata_nxt = ctrl_view(ctrl_r, is_master);
            `IDX_STATUS: rdata_nxt = is_master ? (stat_r & ~`ST_SLAVE_MASK)
                                               : stat_r;
            `IDX_ERR:    rdata_nxt = is_master ? (err_r & ~`ERR_SLAVE_MASK)
                                               : err_r;
            `IDX_LEN:    rdata_nxt = len_r;
            `IDX_DIV:    rdata_nxt = div_r;
            `IDX_MUL:    rdata_nxt = mul_r;
            `IDX_ID:     rdata_nxt = buf_ok ? id_r : 8'h00;
            default:     rdata_nxt = 8'h00;
          endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r   <= `CFG_RESET;
      ctrl_r  <= `CTRL_RESET;
      ptr_r   <= 8'h00;
      stat_r  <= 8'h00;
      err_r   <= 8'h00;
      len_r   <= 8'h00;
      div_r   <= 8'h00;
      mul_r   <= 8'h00;
      id_r    <= 8'h00;
      halt_r  <= 1'b0;
      int_r   <= 1'b0;
      rdata_r <= 8'h00;
      for (int i = 0; i < 8; i++) frame_r[i] <= 8'h00;
    end else if (clk_en) begin
      cfg_r   <= cfg_nxt;
      ctrl_r  <= ctrl_nxt;
      ptr_r   <= ptr_nxt;
      stat_r  <= stat_nxt;
      err_r   <= err_nxt;
      len_r   <= len_nxt;
      div_r   <= div_nxt;
      mul_r   <= mul_nxt;
      id_r    <= id_nxt;
      halt_r  <= halt_nxt;
      int_r   <= int_nxt;
      rdata_r <= rdata_nxt;
      frame_r <= frame_nxt;
    end
  end

  assign sfr_rdata      = rdata_r;
  assign cfg_out        = link_config_type'(cfg_r[7:5]);
  assign ctrl_out       = ctrl_r;
  assign length_out     = len_r;
  assign divider_out    = div_r;
  assign multiplier_out = mul_r;
  assign identifier_out = id_r;
  // Auto-baud only means something to a slave
  assign use_auto_baud  = cfg_r[`CFG_AUTO] & is_slave;
  assign engine_halted  = halt_r;
  assign interrupt_pending = int_r;

  property p_cfg_write;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && sfr_wr && sfr_addr == `CFG_ADDR) |=>
        cfg_r == ($past(sfr_wdata) & `CFG_MASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("Config write not stored");
  property p_auto_baud;
    @(posedge core_clk) disable iff (!resetn)
      is_master |-> !use_auto_baud;
  endproperty
  a_auto_baud: assert property (p_auto_baud)
    else $error("Auto baud active in master mode");
  property p_start_master;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && is_slave && !$past(ctrl_r[0])) |=> !ctrl_r[0] || is_master;
  endproperty
  a_start_master: assert property (p_start_master)
    else $error("Start set in slave mode");
  property p_clear_reads_zero;
    @(posedge core_clk) disable iff (!resetn)
      ctrl_r[3:2] == 2'b00;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("Clear bits held");
  property p_auto_clear;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && finish) |=> (ctrl_r[`CTRL_START] == 1'b0 &&
                              ctrl_r[`CTRL_WAKE] == 1'b0 &&
                              ctrl_r[`CTRL_ACK] == 1'b0);
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("Request bits survived completion");
  property p_stop_halts;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && is_slave && data_wr && ptr_r == 8'h08 &&
       sfr_wdata[7] && !eng_break_seen) |=> engine_halted;
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("Stop did not halt");
  property p_err_clear;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && data_wr && ptr_r == 8'h08 && sfr_wdata[2] &&
       !eng_evt.error && eng_evt.err_flags == 8'h00) |=> err_r == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("Errors not cleared");
  property p_id_guard;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && is_slave && !buf_ok && !eng_rx_id_valid) |=> $stable(id_r);
  endproperty
  a_id_guard: assert property (p_id_guard)
    else $error("Identifier changed without request");
endmodule : lin_register_interface

// ===== core/lin_regs_cfg.svh
// Constants for the link register interface: offsets, fields, resets.
// Assumes an 8-bit special-function bus with byte-wide strobes.
`ifndef LIN_REGS_CFG_SVH
`define LIN_REGS_CFG_SVH
`define CFG_ADDR          8'h95
`define PTR_ADDR          8'h92
`define DATA_ADDR         8'h93
`define IDX_FRAME_LAST    4'h7
`define IDX_CTRL          4'h8
`define IDX_STATUS        4'h9
`define IDX_ERR           4'ha
`define IDX_LEN           4'hb
`define IDX_DIV           4'hc
`define IDX_MUL           4'hd
`define IDX_ID            4'he
`define CFG_RESET         8'h00
`define CTRL_RESET        8'h00
`define CFG_MASK          8'he0
`define CTRL_STOP         7
`define CTRL_SLEEP        6
`define CTRL_DIR          5
`define CTRL_ACK          4
`define CTRL_CLR_INT      3
`define CTRL_CLR_ERR      2
`define CTRL_WAKE         1
`define CTRL_START        0
`define ERR_SLAVE_MASK    8'h18
`define ID_MASK           8'h3f
`define CFG_MASTER        6
`define CFG_AUTO          5
`define ST_DONE           0
`define ST_WAKE           1
`define ST_ERR            2
`define ST_INT            3
`define ST_REQ            4
`define ST_ABORT          5
`define ST_IDLE           6
`define ST_ACTIVE         7
`define ST_SLAVE_MASK     8'h30
`define ERR_USED_MASK     8'h1f
`endif

// ===== core/lin_regs_pkg.sv
// Types for the link register interface.
// Assumes lin_regs_cfg.svh supplies the numbers.
package lin_regs_pkg;
  typedef struct packed {
    logic       enable;
    logic       master;
    logic       auto_baud;
  } link_config_type;
  typedef struct packed {
    logic       done;
    logic       error;
    logic       wakeup;
    logic       data_request;
    logic       active;
    logic       idle_timeout;
    logic       abort;
    logic [7:0] err_flags;
  } engine_event_type;
endpackage : lin_regs_pkg

// ===== tb/lin_engine_model.sv
// Behavioural framing engine facing the register interface.
// Assumes the bench triggers headers, breaks and errors by pulses.
`timescale 1ns/1ps
module lin_engine_model
  import lin_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Register side
  input  wire logic [7:0]  ctrl,
  output engine_event_type evt,
  output logic      [7:0]  rx_byte,
  output logic      [2:0]  rx_index,
  output logic             rx_valid,
  output logic      [5:0]  rx_id,
  output logic             rx_id_valid,
  output logic             break_seen,
  // Bench triggers
  input  wire logic        hdr_go,
  input  wire logic        brk_go,
  input  wire logic        err_go
);
  logic [4:0] busy_r;
  logic [3:0] hdr_r;
  logic [7:0] noise_r;
  // Idle lines toggle each cycle so stale values are never mistaken
  assign rx_valid    = (hdr_r == 4'h3);
  assign rx_index    = rx_valid ? 3'h2 : noise_r[2:0];
  assign rx_byte     = rx_valid ? 8'h5a : noise_r;
  assign rx_id_valid = (hdr_r == 4'h4);
  assign rx_id       = rx_id_valid ? 6'h15 : noise_r[5:0];
  assign break_seen  = brk_go;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r  <= 5'h00;
      hdr_r   <= 4'h0;
      noise_r <= 8'h00;
      evt     <= '0;
    end else begin
      noise_r          <= noise_r + 8'h01;
      evt.done         <= (busy_r == 5'h01);
      evt.error        <= err_go;
      // Error flags are a pulse: zero unless an error is reported
      evt.err_flags    <= err_go ? 8'h1f : 8'h00;
      evt.active       <= hdr_go | (hdr_r > 4'h1);
      evt.data_request <= (hdr_r == 4'h1);
      hdr_r <= hdr_go ? 4'h6 : (hdr_r != 4'h0) ? hdr_r - 4'h1 : 4'h0;
      // Guard on done: the request bits drop only one edge after it
      if (busy_r != 5'h00)
        busy_r <= busy_r - 5'h01;
      else if ((ctrl[0] | ctrl[1] | ctrl[4]) & !evt.done)
        busy_r <= 5'h0c;
    end
  end
endmodule : lin_engine_model

// ===== tb/tb_top.sv
// Self-checking bench: register traffic in master and slave mode.
// Assumes the engine model answers requests on the same clock.
`timescale 1ns/1ps
`include "lin_regs_cfg.svh"
module tb_top;
  import lin_regs_pkg::*;
  logic             core_clk = 1'b0;
  logic             resetn = 1'b0;
  logic [7:0]       sfr_addr = 8'h00;
  logic [7:0]       sfr_wdata = 8'h00;
  logic             sfr_wr = 1'b0;
  logic             sfr_rd = 1'b0;
  logic             hdr_go = 1'b0;
  logic             brk_go = 1'b0;
  logic             err_go = 1'b0;
  logic             rd_pend = 1'b0;
  logic [7:0]       sfr_rdata, eng_rx_byte, ctrl_out, length_out;
  logic [7:0]       divider_out, multiplier_out, identifier_out;
  logic [2:0]       eng_rx_index;
  logic [5:0]       eng_rx_id;
  logic             eng_rx_valid, eng_rx_id_valid, eng_break_seen;
  logic             use_auto_baud, engine_halted, interrupt_pending;
  engine_event_type eng_evt;
  link_config_type  cfg_out;
  logic [7:0]       exp_q[$];
  logic [7:0]       img[8];
  logic [31:0]      seed = 32'h7512d0eb;
  int               err_count = 0;
  int               samples_checked = 0;
  always #4 core_clk = ~core_clk;
  lin_register_interface lin_register_interface_inst (
    .core_clk, .resetn, .clk_en(1'b1), .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .eng_evt, .eng_rx_byte, .eng_rx_index,
    .eng_rx_valid, .eng_rx_id, .eng_rx_id_valid, .eng_break_seen,
    .cfg_out, .ctrl_out, .length_out, .divider_out, .multiplier_out,
    .identifier_out, .use_auto_baud, .engine_halted, .interrupt_pending);
  lin_engine_model lin_engine_model_inst (
    .core_clk, .resetn, .ctrl(ctrl_out), .evt(eng_evt),
    .rx_byte(eng_rx_byte), .rx_index(eng_rx_index),
    .rx_valid(eng_rx_valid), .rx_id(eng_rx_id),
    .rx_id_valid(eng_rx_id_valid), .break_seen(eng_break_seen),
    .hdr_go, .brk_go, .err_go);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Read data lands at the taking edge; sample it half a cycle later
  always @(posedge core_clk) rd_pend <= sfr_rd;
  always @(negedge core_clk) begin
    if (rd_pend === 1'b1)
      check(sfr_rdata, exp_q.pop_front());
  end
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
                     input logic r);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = !r;
    sfr_rd    = r;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : acc
  task automatic dr(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 8'h00, 1'b1);
  endtask : dr
  task automatic iw(input logic [3:0] i, input logic [7:0] d);
    acc(`PTR_ADDR, {4'h0, i}, 1'b0);
    acc(`DATA_ADDR, d, 1'b0);
  endtask : iw
  task automatic ir(input logic [3:0] i, input logic [7:0] e);
    acc(`PTR_ADDR, {4'h0, i}, 1'b0);
    dr(`DATA_ADDR, e);
  endtask : ir
  task automatic kick(input int k);
    hdr_go = (k == 0);
    brk_go = (k == 1);
    err_go = (k == 2);
    @(posedge core_clk);
    #1;
    {hdr_go, brk_go, err_go} = 3'b000;
    @(posedge core_clk);
    #1;
  endtask : kick
  task automatic wait_on(input int k);
    int n;
    n = 0;
    while ((k ? eng_evt.done : eng_evt.data_request) !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if ((k ? eng_evt.done : eng_evt.data_request) !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_on
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    dr(`CFG_ADDR, `CFG_RESET);
    ir(`IDX_CTRL, `CTRL_RESET);
    acc(`CFG_ADDR, 8'hff, 1'b0);
    dr(`CFG_ADDR, `CFG_MASK);
    check({5'h00, cfg_out}, 8'h07);
    check({7'h00, use_auto_baud}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      img[i] = seed[7:0];
      iw(i[3:0], img[i]);
    end
    for (int i = 0; i < 8; i++) ir(i[3:0], img[i]);
    ir(4'hf, 8'h00);
    seed = lfsr(seed);
    iw(`IDX_LEN, seed[7:0]);
    ir(`IDX_LEN, seed[7:0]);
    check(length_out, seed[7:0]);
    iw(`IDX_MUL, seed[15:8]);
    ir(`IDX_MUL, seed[15:8]);
    check(multiplier_out, seed[15:8]);
    iw(`IDX_DIV, 8'h3c);
    check(divider_out, 8'h3c);
    iw(`IDX_CTRL, 8'hff);
    ir(`IDX_CTRL, 8'h23);
    wait_on(1);
    ir(`IDX_CTRL, 8'h20);
    check({7'h00, interrupt_pending}, 8'h01);
    ir(`IDX_STATUS, 8'h09);
    iw(`IDX_CTRL, 8'h08);
    ir(`IDX_STATUS, 8'h01);
    check({7'h00, interrupt_pending}, 8'h00);
    ir(`IDX_CTRL, 8'h00);
    acc(`CFG_ADDR, 8'ha0, 1'b0);
    check({7'h00, use_auto_baud}, 8'h01);
    ir(`IDX_DIV, 8'h3c);
    iw(4'h0, 8'haa);
    ir(4'h0, 8'h00);
    kick(0);
    wait_on(0);
    iw(4'h0, 8'haa);
    ir(4'h0, 8'haa);
    ir(4'h2, 8'h5a);
    ir(`IDX_ID, 8'h15);
    check(identifier_out, 8'h15);
    ir(`IDX_STATUS, 8'h19);
    acc(`CFG_ADDR, 8'he0, 1'b0);
    ir(`IDX_STATUS, 8'h09);
    acc(`CFG_ADDR, 8'ha0, 1'b0);
    iw(`IDX_CTRL, 8'h73);
    ir(`IDX_CTRL, 8'h72);
    check(ctrl_out, 8'h72);
    wait_on(1);
    ir(`IDX_CTRL, 8'h60);
    kick(2);
    ir(`IDX_ERR, 8'h1f);
    acc(`CFG_ADDR, 8'he0, 1'b0);
    ir(`IDX_ERR, 8'h07);
    acc(`CFG_ADDR, 8'ha0, 1'b0);
    iw(`IDX_CTRL, 8'h04);
    ir(`IDX_ERR, 8'h00);
    iw(`IDX_CTRL, 8'h80);
    check({7'h00, engine_halted}, 8'h01);
    ir(`IDX_CTRL, 8'h00);
    kick(1);
    check({7'h00, engine_halted}, 8'h00);
    acc(`CFG_ADDR, 8'he0, 1'b0);
    check({7'h00, use_auto_baud}, 8'h00);
    print_verdict();
  end
endmodule : tb_top
